/* rtl/rrc_exec.sv */
`timescale 1ns/1ns
`default_nettype none
module rrc_exec
    import rrc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic ISSUE,
    input wire logic [23:0] OPCODE,
    input wire logic EXC_PENDING,
    input wire logic CARRY_IN,
    input wire logic [15:0] DEFAULT_WORKING_REG_RD_DATA [16],
    input wire logic [15:0] MEM_RDATA,
    output logic BUSY,
    output logic DONE,
    output var rrc_mem_req_t MEM_REQ,
    output var rrc_default_working_reg_wr_t DEFAULT_WORKING_REG_WR,
    output var rrc_default_working_reg_wr_t PTR_WR,
    output logic PC_LOAD,
    output logic [22:0] PC_VALUE,
    output logic IR_FORCE_NOP,
    output logic [23:0] IR_VALUE,
    output logic FLAGS_WE,
    output var rrc_flags_t FLAGS
);
    typedef struct packed {
        rrc_state_t st;
        logic exc;
        logic byte_m;
        logic file_form;
        logic dest_w;
        logic [12:0] faddr;
        logic [2:0] dmode;
        logic [3:0] dreg;
        logic [15:0] daddr;
        logic [15:0] sp;
        logic [6:0] pc_hi;
        logic busy;
        logic done;
        rrc_mem_req_t mem;
        rrc_default_working_reg_wr_t wr;
        rrc_default_working_reg_wr_t ptr;
        logic pc_load;
        logic [22:0] pc_val;
        logic ir_nop;
        logic flags_we;
        rrc_flags_t flags;
    } rrc_regs_t;

    rrc_regs_t r_q, r_d;
    logic is_ret, is_file, is_default_working_reg, byte_op;
    logic [15:0] step, src_ptr, src_eff, dst_ptr, dst_eff, rot_res, rot_in;
    logic [2:0] smode, dmode;
    logic [3:0] sreg, dreg;
    rrc_flags_t rot_flags;

    // Decode of the three opcodes handled here
    assign is_ret = (OPCODE == RRC_RETURN_OPC);
    assign is_file = (OPCODE[23:16] == RRC_FILE_HI) && OPCODE[15];
    assign is_default_working_reg = (OPCODE[23:16] == RRC_DEFAULT_WORKING_REG_HI) && OPCODE[15];
    assign byte_op = OPCODE[RRC_B_BIT];
    assign step = byte_op ? 16'h0001 : 16'h0002;
    assign dmode = OPCODE[13:11];
    assign dreg = OPCODE[10:7];
    assign smode = OPCODE[6:4];
    assign sreg = OPCODE[3:0];
    assign src_ptr = DEFAULT_WORKING_REG_RD_DATA[sreg];
    assign dst_ptr = DEFAULT_WORKING_REG_RD_DATA[dreg];
    // Pre-modes address the stepped pointer, others the old one
    assign src_eff = (smode == RRC_AM_PREINC) ? src_ptr + step :
        (smode == RRC_AM_PREDEC) ? src_ptr - step : src_ptr;
    assign dst_eff = (dmode == RRC_AM_PREINC) ? dst_ptr + step :
        (dmode == RRC_AM_PREDEC) ? dst_ptr - step : dst_ptr;

    // Operand comes from a register directly or from the memory read
    assign rot_in = (r_q.st == RRC_IDLE) ? src_ptr : MEM_RDATA;

    rrc_rotate u_rot (
        .operand(rot_in),
        .carry_in(CARRY_IN),
        .byte_mode(r_q.st == RRC_IDLE ? byte_op : r_q.byte_m),
        .result(rot_res),
        .flags(rot_flags)
    );

    function automatic logic [15:0] ptr_next(input logic [2:0] m,
        input logic [15:0] p, input logic [15:0] s);
        logic [15:0] v;
        v = p;
        if (m == RRC_AM_POSTINC || m == RRC_AM_PREINC) begin
            v = p + s;
        end else if (m == RRC_AM_POSTDEC || m == RRC_AM_PREDEC) begin
            v = p - s;
        end
        return v;
    endfunction

    // Next-state logic for the whole engine
    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        r_d.mem = '0;
        r_d.wr = '0;
        r_d.ptr = '0;
        r_d.pc_load = 1'b0;
        r_d.ir_nop = 1'b0;
        r_d.flags_we = 1'b0;
        unique case (r_q.st)
            RRC_IDLE: begin
                if (ISSUE && is_ret) begin
                    // First pop: SP-2 reads PC high bits
                    r_d.exc = EXC_PENDING;
                    r_d.sp = DEFAULT_WORKING_REG_RD_DATA[RRC_STACK_DEFAULT_WORKING_REG] - RRC_STACK_STEP;
                    r_d.mem.rd = 1'b1;
                    r_d.mem.addr = r_d.sp;
                    r_d.busy = 1'b1;
                    r_d.st = RRC_POP_HI;
                end else if (ISSUE && is_file) begin
                    r_d.byte_m = byte_op;
                    r_d.file_form = 1'b1;
                    r_d.dest_w = OPCODE[RRC_D_BIT];
                    r_d.faddr = OPCODE[12:0];
                    r_d.mem.rd = 1'b1;
                    r_d.mem.addr = {3'b000, OPCODE[12:0]};
                    r_d.busy = 1'b1;
                    r_d.st = RRC_RD_SRC;
                end else if (ISSUE && is_default_working_reg) begin
                    r_d.byte_m = byte_op;
                    r_d.file_form = 1'b0;
                    r_d.dmode = dmode;
                    r_d.dreg = dreg;
                    r_d.daddr = dst_eff;
                    r_d.busy = 1'b1;
                    if (smode != RRC_AM_DIRECT) begin
                        r_d.mem.rd = 1'b1;
                        r_d.mem.addr = src_eff;
                        r_d.ptr.we = (smode != RRC_AM_IND);
                        r_d.ptr.idx = sreg;
                        r_d.ptr.data = ptr_next(smode, src_ptr, step);
                        r_d.st = RRC_RD_SRC;
                    end else begin
                        // Direct source rotates at once
                        r_d.flags = rot_flags;
                        r_d.flags_we = 1'b1;
                        r_d.mem.wdata = rot_res;
                        r_d.st = RRC_WR_DST;
                    end
                end
            end
            RRC_POP_HI: begin
                r_d.pc_hi = MEM_RDATA[6:0];
                if (r_q.exc) begin
                    // Pending exception ends in two cycles
                    r_d.pc_load = 1'b1;
                    r_d.pc_val = {MEM_RDATA[6:0], r_q.pc_val[15:0]};
                    r_d.ptr.we = 1'b1;
                    r_d.ptr.idx = RRC_STACK_DEFAULT_WORKING_REG;
                    r_d.ptr.data = r_q.sp;
                    r_d.ir_nop = 1'b1;
                    r_d.busy = 1'b0;
                    r_d.done = 1'b1;
                    r_d.st = RRC_IDLE;
                end else begin
                    r_d.sp = r_q.sp - RRC_STACK_STEP;
                    r_d.mem.rd = 1'b1;
                    r_d.mem.addr = r_d.sp;
                    r_d.st = RRC_POP_LO;
                end
            end
            RRC_POP_LO: begin
                r_d.pc_load = 1'b1;
                r_d.pc_val = {r_q.pc_hi, MEM_RDATA};
                r_d.ptr.we = 1'b1;
                r_d.ptr.idx = RRC_STACK_DEFAULT_WORKING_REG;
                r_d.ptr.data = r_q.sp;
                r_d.ir_nop = 1'b1;
                r_d.busy = 1'b0;
                r_d.done = 1'b1;
                r_d.st = RRC_IDLE;
            end
            RRC_RD_SRC: begin
                r_d.flags = rot_flags;
                r_d.flags_we = 1'b1;
                r_d.mem.wdata = rot_res;
                r_d.st = RRC_WR_DST;
            end
            RRC_WR_DST: begin
                // Destination write: file, default reg, Wd or [Wd]
                if (r_q.file_form && !r_q.dest_w) begin
                    r_d.mem.wr = 1'b1;
                    r_d.mem.addr = {3'b000, r_q.faddr};
                    r_d.mem.wdata = r_q.mem.wdata;
                    r_d.mem.byte_en_hi = !r_q.byte_m;
                end else if (r_q.file_form ||
                    r_q.dmode == RRC_AM_DIRECT) begin
                    r_d.wr.we = 1'b1;
                    r_d.wr.byte_only = r_q.byte_m;
                    r_d.wr.idx = r_q.file_form ? RRC_DEFAULT_DEFAULT_WORKING_REG : r_q.dreg;
                    r_d.wr.data = r_q.mem.wdata;
                end else begin
                    r_d.mem.wr = 1'b1;
                    r_d.mem.addr = r_q.daddr;
                    r_d.mem.wdata = r_q.mem.wdata;
                    r_d.mem.byte_en_hi = !r_q.byte_m;
                    r_d.ptr.we = (r_q.dmode != RRC_AM_IND);
                    r_d.ptr.idx = r_q.dreg;
                    r_d.ptr.data = ptr_next(r_q.dmode,
                        DEFAULT_WORKING_REG_RD_DATA[r_q.dreg], r_q.byte_m ? 16'h0001 : 16'h0002);
                end
                r_d.busy = 1'b0;
                r_d.done = 1'b1;
                r_d.st = RRC_IDLE;
            end
            default: r_d.st = RRC_IDLE;
        endcase
    end

    // One register bank for all engine state
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign BUSY = r_q.busy;
    assign DONE = r_q.done;
    assign MEM_REQ = r_q.mem;
    assign DEFAULT_WORKING_REG_WR = r_q.wr;
    assign PTR_WR = r_q.ptr;
    assign PC_LOAD = r_q.pc_load;
    assign PC_VALUE = r_q.pc_val;
    assign IR_FORCE_NOP = r_q.ir_nop;
    assign IR_VALUE = RRC_NOP_OPC;
    assign FLAGS_WE = r_q.flags_we;
    assign FLAGS = r_q.flags;

    // Return cycle counting from issue to done
    logic [2:0] ret_cnt_q;
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ret_cnt_q <= 3'h0;
        end else if (ISSUE && is_ret && r_q.st == RRC_IDLE) begin
            ret_cnt_q <= 3'h1;
        end else if (r_q.busy) begin
            ret_cnt_q <= ret_cnt_q + 3'h1;
        end
    end

    // Counter ties the pc load to the documented cycle budget
    chk_ret_cycle_cnt: assert property (@(posedge CLOCK)
        disable iff (!RESET_N)
        PC_LOAD |-> ret_cnt_q == (r_q.exc ? 3'(RRC_RET_CYCLES_EXC) :
        3'(RRC_RET_CYCLES)))
        else $error("return cycle count wrong");

    sequence s_ret_issue;
        ISSUE && is_ret && r_q.st == RRC_IDLE;
    endsequence

    chk_ret_three_cycles: assert property (@(posedge CLOCK)
        disable iff (!RESET_N)
        s_ret_issue and !EXC_PENDING |-> ##3 (DONE && PC_LOAD))
        else $error("return did not finish in three cycles");
    chk_ret_two_cycles: assert property (@(posedge CLOCK)
        disable iff (!RESET_N)
        s_ret_issue and EXC_PENDING |-> ##2 (DONE && PC_LOAD))
        else $error("return with exception did not finish in two");
    chk_ret_no_flags: assert property (@(posedge CLOCK)
        disable iff (!RESET_N)
        s_ret_issue |-> !FLAGS_WE [*3])
        else $error("return changed status flags");
    chk_ret_nop_force: assert property (@(posedge CLOCK)
        disable iff (!RESET_N)
        PC_LOAD |-> IR_FORCE_NOP && PTR_WR.we && PTR_WR.idx == RRC_STACK_DEFAULT_WORKING_REG)
        else $error("pc load without nop and stack update");
    chk_ret_sp_step: assert property (@(posedge CLOCK)
        disable iff (!RESET_N)
        s_ret_issue and !EXC_PENDING |-> ##3
        (PTR_WR.data == $past(DEFAULT_WORKING_REG_RD_DATA[RRC_STACK_DEFAULT_WORKING_REG], 3) - 16'h0004))
        else $error("stack pointer not lowered by four");
    chk_rot_carry_word: assert property (@(posedge CLOCK)
        disable iff (!RESET_N)
        ISSUE && is_default_working_reg && !byte_op && smode == RRC_AM_DIRECT
        && r_q.st == RRC_IDLE |=> FLAGS_WE
        && FLAGS.carry == $past(src_ptr[15]))
        else $error("word rotate carry wrong");
    chk_file_dest_sel: assert property (@(posedge CLOCK)
        disable iff (!RESET_N)
        ISSUE && is_file && OPCODE[RRC_D_BIT] && r_q.st == RRC_IDLE
        |-> ##3 (DEFAULT_WORKING_REG_WR.we && DEFAULT_WORKING_REG_WR.idx == RRC_DEFAULT_DEFAULT_WORKING_REG))
        else $error("file rotate not written to default register");
    chk_byte_lane: assert property (@(posedge CLOCK)
        disable iff (!RESET_N)
        DEFAULT_WORKING_REG_WR.we |-> DEFAULT_WORKING_REG_WR.byte_only == $past(r_q.byte_m))
        else $error("byte write touched the high byte");
endmodule
`default_nettype wire

/* rtl/rrc_pkg.sv */
package rrc_pkg;
    localparam logic [23:0] RRC_RETURN_OPC = 24'h06_0000;
    localparam logic [7:0] RRC_FILE_HI = 8'hD6;
    localparam logic [7:0] RRC_DEFAULT_WORKING_REG_HI = 8'hD2;
    localparam int RRC_B_BIT = 14;
    localparam int RRC_D_BIT = 13;
    localparam logic [3:0] RRC_DEFAULT_DEFAULT_WORKING_REG = 4'h0;
    localparam logic [3:0] RRC_STACK_DEFAULT_WORKING_REG = 4'hF;
    localparam logic [15:0] RRC_STACK_STEP = 16'h0002;
    localparam logic [23:0] RRC_NOP_OPC = 24'h00_0000;
    localparam int RRC_RET_CYCLES = 3;
    localparam int RRC_RET_CYCLES_EXC = 2;
    // Address modes of the q and p fields
    localparam logic [2:0] RRC_AM_DIRECT = 3'h0;
    localparam logic [2:0] RRC_AM_IND = 3'h1;
    localparam logic [2:0] RRC_AM_POSTDEC = 3'h2;
    localparam logic [2:0] RRC_AM_POSTINC = 3'h3;
    localparam logic [2:0] RRC_AM_PREDEC = 3'h4;
    localparam logic [2:0] RRC_AM_PREINC = 3'h5;

    typedef enum logic [2:0] {
        RRC_IDLE, RRC_POP_HI, RRC_POP_LO, RRC_RD_SRC, RRC_WR_DST
    } rrc_state_t;

    typedef struct packed {
        logic neg;
        logic zero;
        logic carry;
    } rrc_flags_t;

    // Data memory request to the stack/data RAM
    typedef struct packed {
        logic rd;
        logic wr;
        logic byte_en_hi;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rrc_mem_req_t;

    // Working register file write port
    typedef struct packed {
        logic we;
        logic byte_only;
        logic [3:0] idx;
        logic [15:0] data;
    } rrc_default_working_reg_wr_t;
endpackage

/* rtl/rrc_rotate.sv */
`timescale 1ns/1ns
`default_nettype none
module rrc_rotate
    import rrc_pkg::*;
(
    input wire logic [15:0] operand,
    input wire logic carry_in,
    input wire logic byte_mode,
    output logic [15:0] result,
    output var rrc_flags_t flags
);
    // Pure datapath so the engine can register it in the same cycle
    always_comb begin
        if (byte_mode) begin
            result = {operand[15:8], operand[6:0], carry_in};
            flags.carry = operand[7];
            flags.neg = operand[6];
            flags.zero = ({operand[6:0], carry_in} == 8'h00);
        end else begin
            result = {operand[14:0], carry_in};
            flags.carry = operand[15];
            flags.neg = operand[14];
            flags.zero = ({operand[14:0], carry_in} == 16'h0000);
        end
    end
endmodule
`default_nettype wire

/* verification/rrc_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module rrc_mem_model
    import rrc_pkg::*;
(
    input wire logic CLOCK,
    input wire rrc_mem_req_t MEM_REQ,
    output logic [15:0] MEM_RDATA
);
    logic [15:0] mem [logic [15:0]];
    logic [15:0] last_q = 16'h0000;

    // Data only during a read; a moving wrong value otherwise, so a late
    // sample by the engine cannot pass by luck
    always_comb begin
        MEM_RDATA = ~last_q;
        if (MEM_REQ.rd && mem.exists(MEM_REQ.addr & 16'hFFFE)) begin
            MEM_RDATA = mem[MEM_REQ.addr & 16'hFFFE];
        end
    end

    // Writes land at the edge; a byte write keeps the high byte
    always @(posedge CLOCK) begin
        last_q <= MEM_RDATA;
        if (MEM_REQ.wr) begin
            if (MEM_REQ.byte_en_hi) begin
                mem[MEM_REQ.addr & 16'hFFFE] = MEM_REQ.wdata;
            end else begin
                mem[MEM_REQ.addr & 16'hFFFE][7:0] = MEM_REQ.wdata[7:0];
            end
        end
    end
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import rrc_pkg::*;
    logic clock, reset_n, issue, exc_pending, carry_in;
    logic [23:0] opcode;
    logic [15:0] wr_file [16];
    logic [15:0] mem_rdata;
    logic busy, done, pc_load, ir_force_nop, flags_we;
    logic [22:0] pc_value;
    logic [23:0] ir_value;
    rrc_mem_req_t mem_req, mw_s;
    rrc_default_working_reg_wr_t default_working_reg_wr, ptr_wr, wr_s, pt_s;
    rrc_flags_t flags, fl_s;
    logic [22:0] pc_s;
    logic nop_s;
    int n_fwe, n_done, n_mismatch, compares;

    rrc_exec i_dut (.CLOCK(clock), .RESET_N(reset_n), .ISSUE(issue),
        .OPCODE(opcode), .EXC_PENDING(exc_pending), .CARRY_IN(carry_in),
        .DEFAULT_WORKING_REG_RD_DATA(wr_file), .MEM_RDATA(mem_rdata), .BUSY(busy),
        .DONE(done), .MEM_REQ(mem_req), .DEFAULT_WORKING_REG_WR(default_working_reg_wr), .PTR_WR(ptr_wr),
        .PC_LOAD(pc_load), .PC_VALUE(pc_value), .IR_FORCE_NOP(ir_force_nop),
        .IR_VALUE(ir_value), .FLAGS_WE(flags_we), .FLAGS(flags));
    rrc_mem_model i_mem (.CLOCK(clock), .MEM_REQ(mem_req),
        .MEM_RDATA(mem_rdata));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Pulses are caught mid-cycle, well away from the launching edge
    always @(negedge clock) begin
        if (default_working_reg_wr.we) wr_s = default_working_reg_wr;
        if (ptr_wr.we) pt_s = ptr_wr;
        if (mem_req.wr) mw_s = mem_req;
        if (flags_we) begin
            fl_s = flags;
            n_fwe++;
        end
        if (pc_load) begin
            pc_s = pc_value;
            nop_s = ir_force_nop;
        end
        if (done) n_done++;
    end

    task automatic chk(input string name, input logic [23:0] e, g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic close_out;
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic [16:0] rot(input logic [15:0] v,
        input logic c, b);
        return b ? {v[7], 8'h00, v[6:0], c} : {v[15], v[14:0], c};
    endfunction

    // Entered just after an edge; leaves just after an edge
    task automatic run_op(input logic [23:0] opc, input int exp_n);
        int n;
        // DONE seen after edge k leaves n at k, the issue edge counting as edge 1
        n = 1;
        wr_s = '0; pt_s = '0; mw_s = '0; fl_s = '0; n_fwe = 0;
        issue = 1'b1;
        opcode = opc;
        @(posedge clock);
        #1 issue = 1'b0;
        chk("busy", 24'h00_0001, 24'(busy));
        while (done !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1 n++;
        end
        chk("cycles", 24'(exp_n), 24'(n));
        @(posedge clock);
        #1;
    endtask

    task automatic chk_fl(input logic [16:0] r, input logic b);
        logic [15:0] m;
        m = b ? 16'h00FF : 16'hFFFF;
        chk("flag writes", 24'h00_0001, 24'(n_fwe));
        chk("flags", 24'({b ? r[7] : r[15], (r[15:0] & m) == 16'h0000,
            r[16]}), 24'(fl_s));
    endtask

    task automatic t_ret(input logic exc, input logic [15:0] hi, lo,
        input logic [15:0] old_lo);
        wr_file[15] = 16'h1988;
        i_mem.mem[16'h1986] = hi;
        i_mem.mem[16'h1984] = lo;
        exc_pending = exc;
        run_op(RRC_RETURN_OPC, exc ? 2 : 3);
        chk("pc", 24'({hi[6:0], exc ? old_lo : lo}), 24'(pc_s));
        chk("nop", 24'h00_0001, 24'(nop_s));
        chk("ir", 24'(RRC_NOP_OPC), ir_value);
        chk("sp", 24'({1'b1, 4'hF, exc ? 16'h1986 : 16'h1984}),
            24'({pt_s.we, pt_s.idx, pt_s.data}));
        chk("flag writes", 24'h00_0000, 24'(n_fwe));
        exc_pending = 1'b0;
    endtask

    task automatic t_file(input logic b, d, c, input logic [12:0] f,
        input logic [15:0] v);
        logic [16:0] r;
        logic [15:0] m;
        m = b ? 16'h00FF : 16'hFFFF;
        r = rot(v, c, b);
        i_mem.mem[{3'h0, f}] = v;
        carry_in = c;
        run_op({8'hD6, 1'b1, b, d, f}, 3);
        chk_fl(r, b);
        if (d) begin
            chk("default_working_reg", 24'({1'b1, RRC_DEFAULT_DEFAULT_WORKING_REG, r[15:0] & m}),
                24'({wr_s.we, wr_s.idx, wr_s.data & m}));
        end else begin
            chk("mem addr", 24'({1'b1, 3'h0, f}),
                24'({mw_s.wr, mw_s.addr}));
            chk("mem data", 24'({!b, r[15:0] & m}),
                24'({mw_s.byte_en_hi, mw_s.wdata & m}));
        end
    endtask

    task automatic t_default_working_reg(input logic b, input logic [2:0] q, p,
        input logic c);
        logic [15:0] w, v, m;
        logic [16:0] r;
        w = wr_file[4];
        m = b ? 16'h00FF : 16'hFFFF;
        i_mem.mem[w - 16'h0002] = 16'h8001;
        i_mem.mem[w] = 16'h3689;
        i_mem.mem[w + 16'h0002] = 16'hC040;
        v = p == 3'h0 ? w : p == 3'h4 ? 16'h8001 :
            p == 3'h5 ? 16'hC040 : 16'h3689;
        r = rot(v, c, b);
        carry_in = c;
        run_op({8'hD2, 1'b1, b, q, 4'h6, p, 4'h4}, p == 3'h0 ? 2 : 3);
        chk_fl(r, b);
        if (q == 3'h0) begin
            chk("default_working_reg", 24'({1'b1, 4'h6, b, r[15:0] & m}), 24'({wr_s.we,
                wr_s.idx, wr_s.byte_only, wr_s.data & m}));
        end else begin
            chk("mem wr", 24'({1'b1, wr_file[6]}),
                24'({mw_s.wr, mw_s.addr}));
            chk("mem data", 24'(r[15:0]), 24'(mw_s.wdata));
        end
        if (p >= 3'h2) begin
            chk("ptr", 24'({1'b1, 4'h4, (p == 3'h2 || p == 3'h4) ?
                w - 16'h0002 : w + 16'h0002}),
                24'({pt_s.we, pt_s.idx, pt_s.data}));
        end
    endtask

    // Unknown words and a request during a busy engine go unanswered
    task automatic t_refuse;
        n_done = 0;
        n_fwe = 0;
        issue = 1'b1;
        opcode = 24'hD7_8000;
        @(posedge clock);
        #1 opcode = 24'hD6_0010;
        @(posedge clock);
        #1 opcode = RRC_RETURN_OPC;
        @(posedge clock);
        #1 opcode = 24'hD6_8010;
        @(posedge clock);
        #1 issue = 1'b0;
        repeat (8) @(posedge clock);
        #1 chk("dones", 24'h00_0001, 24'(n_done));
        chk("flag writes", 24'h00_0000, 24'(n_fwe));
    endtask

    initial begin
        reset_n = 1'b0;
        issue = 1'b0;
        opcode = 24'h00_0000;
        exc_pending = 1'b0;
        carry_in = 1'b0;
        foreach (wr_file[i]) wr_file[i] = 16'h0000;
        wr_file[4] = 16'h0400;
        wr_file[6] = 16'h0900;
        repeat (12) @(posedge clock);
        #1 reset_n = 1'b1;
        chk("idle", 24'h00_0000, 24'({busy, done, pc_load, flags_we}));
        t_ret(1'b0, 16'h0001, 16'h7006, 16'h0000);
        t_ret(1'b1, 16'h0055, 16'h1234, 16'h7006);
        t_file(1'b0, 1'b0, 1'b1, 13'h1FFE, 16'h8001);
        t_file(1'b1, 1'b1, 1'b0, 13'h0000, 16'h0080);
        t_file(1'b1, 1'b0, 1'b1, 13'h1232, 16'hE807);
        t_file(1'b0, 1'b1, 1'b0, 13'h0820, 16'h216E);
        for (int i = 0; i < 6; i++) t_default_working_reg(1'b0, 3'h0, 3'(i), i[0]);
        t_default_working_reg(1'b1, 3'h0, 3'h0, 1'b1);
        t_default_working_reg(1'b0, 3'h1, 3'h3, 1'b0);
        t_refuse();
        close_out();
    end

    // Whole run is under a hundred cycles; this only cuts a hang short
    initial begin
        #20000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
